// [verilog/sfw_cfg.svh]
// constants of the file-minus-working subtract core and its register window
// assumes inclusion by bare name from the core module and the testbench
`ifndef SFW_CFG_SVH
`define SFW_CFG_SVH
// register byte offsets
`define SFW_CTRL_OFS 12'h000
`define SFW_INSN_OFS 12'h004
`define SFW_WREG_OFS 12'h008
`define SFW_BANK_OFS 12'h00C
`define SFW_STAT_OFS 12'h010
`define SFW_IDXB_OFS 12'h014
`define SFW_EXEC_OFS 12'h018
// data memory window: page and word index
`define SFW_MEM_PAGE 4'h1
`define SFW_MEM_AW 6
`define SFW_MEM_DEPTH 64
// instruction fields
`define SFW_OPC_HI 15
`define SFW_OPC_LO 10
`define SFW_OPC 6'h17
`define SFW_D_BIT 9
`define SFW_A_BIT 8
`define SFW_F_HI 7
`define SFW_F_LO 0
// control register fields
`define SFW_EXT_BIT 0
// addressing
`define SFW_ILO_MAX 8'h5F
`define SFW_ACC_SPLIT 8'h60
`define SFW_ACC_LO 4'h0
`define SFW_ACC_HI 4'hF
// status bit positions
`define SFW_ST_C 0
`define SFW_ST_HC 1
`define SFW_ST_Z 2
`define SFW_ST_SX 3
`define SFW_ST_N 4
// exec register fields
`define SFW_EX_BUSY 0
`define SFW_EX_ILL 1
`define SFW_EX_EA_LO 16
`define SFW_EX_EA_HI 27
// bus answers
`define SFW_RESP_OK 2'h0
`define SFW_RESP_ERR 2'h2
`endif

// [verilog/sfw_pkg.sv]
// types shared by the subtract core
// assumes sfw_cfg.svh for numeric constants
package sfw_pkg;
  // instruction cycle phases
  typedef enum logic [2:0] {
    SFW_IDLE = 3'h0, // waiting for an instruction
    SFW_Q1 = 3'h1, // decode
    SFW_Q2 = 3'h2, // read file register
    SFW_Q3 = 3'h3, // process data
    SFW_Q4 = 3'h4 // write destination
  } sfw_phase_t;
endpackage

// [verilog/sfw_sub_alu.sv]
// two's complement subtractor with status flag outputs
// assumes operands held stable by the core during the process phase
`timescale 1ns/1ps
module sfw_sub_alu (
  input wire logic [7:0] f_val, // file register operand
  input wire logic [7:0] w_val, // working register operand
  output logic [7:0] diff, // f minus w
  output logic c_flag, // no borrow out of bit 7
  output logic half_carry_flag, // no borrow out of bit 3
  output logic z_flag, // difference is zero
  output logic signed_excess_flag, // signed overflow
  output logic n_flag // result sign
);
  logic [8:0] full_sum; // f + ~w + 1
  logic [4:0] low_sum; // low nibble sum
  // add the inverted subtrahend plus one
  always_comb begin
    full_sum = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001;
    low_sum = {1'b0, f_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
    diff = full_sum[7:0];
    c_flag = full_sum[8];
    half_carry_flag = low_sum[4];
    z_flag = (full_sum[7:0] == 8'h00);
    signed_excess_flag = (f_val[7] ^ w_val[7]) & (f_val[7] ^ full_sum[7]);
    n_flag = full_sum[7];
  end
endmodule // sfw_sub_alu

// [verilog/sfw_core.sv]
// subtract core: executes the file-minus-working instruction over four phases
// assumes an AXI4-Lite master on aclk; sfw_cfg.svh and sfw_pkg compiled first
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sfw_cfg.svh"
module sfw_core (
  input wire logic aclk, // core clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // byte-lane merge of a bus write onto an old value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // data memory window decode
  function automatic logic is_mem(input logic [11:0] addr);
    return addr[11:8] == `SFW_MEM_PAGE;
  endfunction

  sfw_pkg::sfw_phase_t phase_reg; // instruction phase
  logic ext_en_reg; // extended instruction set enable
  logic [15:0] insn_reg; // instruction word
  logic [7:0] w_reg; // working register
  logic [3:0] bank_reg; // bank pointer
  logic [7:0] stat_reg; // status register
  logic [11:0] idxb_reg; // indexed offset base
  logic [11:0] ea_reg; // resolved file address
  logic [7:0] opnd_reg; // file operand read in q2
  logic [7:0] res_reg; // difference from q3
  logic [4:0] flg_reg; // flags from q3 in status order
  logic ill_reg; // last word was not this opcode
  logic [7:0] mem [`SFW_MEM_DEPTH]; // file register storage
  logic [11:0] aw_addr_reg; // held write address
  logic [31:0] w_data_reg; // held write data
  logic [3:0] w_strb_reg; // held strobes
  logic aw_full_reg; // write address held
  logic w_full_reg; // write data held
  logic awready_reg; // awready flop
  logic wready_reg; // wready flop
  logic bvalid_reg; // bvalid flop
  logic [1:0] bresp_reg; // bresp flop
  logic arready_reg; // arready flop
  logic rvalid_reg; // rvalid flop
  logic [31:0] rdata_reg; // rdata flop
  logic [1:0] rresp_reg; // rresp flop
  logic busy; // instruction in flight
  logic do_wr; // bus write performed this cycle
  logic op_ok; // opcode matches
  logic dest_f; // destination is file register
  logic [`SFW_MEM_AW-1:0] ea_idx; // memory index of operand
  logic [`SFW_MEM_AW-1:0] wr_idx; // memory index of bus write
  logic [31:0] old_val; // current value at write target
  logic [31:0] mrg; // merged write value
  logic [31:0] rd_val; // read mux value
  logic rd_err; // unmapped read
  logic wr_err; // unmapped write
  logic [7:0] alu_diff; // alu result
  logic alu_c; // alu carry
  logic alu_half_carry; // alu half carry
  logic alu_z; // alu zero
  logic alu_sgn_excess; // alu overflow
  logic alu_n; // alu negative
  logic [7:0] fa; // instruction file address field

  assign busy = (phase_reg != sfw_pkg::SFW_IDLE);
  assign op_ok = (insn_reg[`SFW_OPC_HI:`SFW_OPC_LO] == `SFW_OPC);
  assign dest_f = insn_reg[`SFW_D_BIT];
  assign fa = insn_reg[`SFW_F_HI:`SFW_F_LO];
  assign ea_idx = ea_reg[`SFW_MEM_AW-1:0];
  assign wr_idx = aw_addr_reg[`SFW_MEM_AW+1:2];
  // bus writes wait while an instruction runs
  assign do_wr = aw_full_reg & w_full_reg & ~bvalid_reg & ~busy;
  assign mrg = wmerge(old_val, w_data_reg, w_strb_reg);

  // subtractor
  sfw_sub_alu u_alu (
    .f_val(opnd_reg),
    .w_val(w_reg),
    .diff(alu_diff),
    .c_flag(alu_c),
    .half_carry_flag(alu_half_carry),
    .z_flag(alu_z),
    .signed_excess_flag(alu_sgn_excess),
    .n_flag(alu_n)
  );

  // write target decode and its present value
  always_comb begin
    wr_err = 1'b0;
    old_val = 32'h00000000;
    if (aw_addr_reg == `SFW_CTRL_OFS) begin
      old_val[`SFW_EXT_BIT] = ext_en_reg;
    end else if (aw_addr_reg == `SFW_INSN_OFS) begin
      old_val[15:0] = insn_reg;
    end else if (aw_addr_reg == `SFW_WREG_OFS) begin
      old_val[7:0] = w_reg;
    end else if (aw_addr_reg == `SFW_BANK_OFS) begin
      old_val[3:0] = bank_reg;
    end else if (aw_addr_reg == `SFW_STAT_OFS) begin
      old_val[7:0] = stat_reg;
    end else if (aw_addr_reg == `SFW_IDXB_OFS) begin
      old_val[11:0] = idxb_reg;
    end else if (aw_addr_reg == `SFW_EXEC_OFS) begin
      old_val = 32'h00000000; // read only, write ignored
    end else if (is_mem(aw_addr_reg)) begin
      old_val[7:0] = mem[wr_idx];
    end else begin
      wr_err = 1'b1;
    end
  end

  // read mux on the offered read address
  always_comb begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr == `SFW_CTRL_OFS) begin
      rd_val[`SFW_EXT_BIT] = ext_en_reg;
    end else if (s_axi_araddr == `SFW_INSN_OFS) begin
      rd_val[15:0] = insn_reg;
    end else if (s_axi_araddr == `SFW_WREG_OFS) begin
      rd_val[7:0] = w_reg;
    end else if (s_axi_araddr == `SFW_BANK_OFS) begin
      rd_val[3:0] = bank_reg;
    end else if (s_axi_araddr == `SFW_STAT_OFS) begin
      rd_val[7:0] = stat_reg;
    end else if (s_axi_araddr == `SFW_IDXB_OFS) begin
      rd_val[11:0] = idxb_reg;
    end else if (s_axi_araddr == `SFW_EXEC_OFS) begin
      rd_val[`SFW_EX_BUSY] = busy;
      rd_val[`SFW_EX_ILL] = ill_reg;
      rd_val[`SFW_EX_EA_HI:`SFW_EX_EA_LO] = ea_reg;
    end else if (is_mem(s_axi_araddr)) begin
      rd_val[7:0] = mem[s_axi_araddr[`SFW_MEM_AW+1:2]];
    end else begin
      rd_err = 1'b1;
    end
  end

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        awready_reg <= 1'b1;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        wready_reg <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `SFW_RESP_OK;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_err ? `SFW_RESP_ERR : `SFW_RESP_OK;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SFW_RESP_OK;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= rd_err ? `SFW_RESP_ERR : `SFW_RESP_OK;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // phase sequencer: one instruction cycle of four phases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= sfw_pkg::SFW_IDLE;
    end else begin
      case (phase_reg)
        sfw_pkg::SFW_IDLE: if (do_wr && aw_addr_reg == `SFW_INSN_OFS) begin
          phase_reg <= sfw_pkg::SFW_Q1;
        end
        sfw_pkg::SFW_Q1: phase_reg <= op_ok ? sfw_pkg::SFW_Q2 : sfw_pkg::SFW_IDLE;
        sfw_pkg::SFW_Q2: phase_reg <= sfw_pkg::SFW_Q3;
        sfw_pkg::SFW_Q3: phase_reg <= sfw_pkg::SFW_Q4;
        default: phase_reg <= sfw_pkg::SFW_IDLE;
      endcase
    end
  end

  // configuration registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_reg <= 1'b0;
      insn_reg <= 16'h0000;
      bank_reg <= 4'h0;
      idxb_reg <= 12'h000;
    end else if (do_wr) begin
      if (aw_addr_reg == `SFW_CTRL_OFS) begin
        ext_en_reg <= mrg[`SFW_EXT_BIT];
      end else if (aw_addr_reg == `SFW_INSN_OFS) begin
        insn_reg <= mrg[15:0];
      end else if (aw_addr_reg == `SFW_BANK_OFS) begin
        bank_reg <= mrg[3:0];
      end else if (aw_addr_reg == `SFW_IDXB_OFS) begin
        idxb_reg <= mrg[11:0];
      end
    end
  end

  // q1: decode and resolve the operand address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ea_reg <= 12'h000;
      ill_reg <= 1'b0;
    end else if (phase_reg == sfw_pkg::SFW_Q1) begin
      ill_reg <= ~op_ok;
      if (insn_reg[`SFW_A_BIT]) begin
        ea_reg <= {bank_reg, fa};
      end else if (ext_en_reg && fa <= `SFW_ILO_MAX) begin
        ea_reg <= idxb_reg + {4'h0, fa};
      end else if (fa < `SFW_ACC_SPLIT) begin
        ea_reg <= {`SFW_ACC_LO, fa};
      end else begin
        ea_reg <= {`SFW_ACC_HI, fa};
      end
    end
  end

  // q2 read, q3 process
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opnd_reg <= 8'h00;
      res_reg <= 8'h00;
      flg_reg <= 5'h00;
    end else if (phase_reg == sfw_pkg::SFW_Q2) begin
      opnd_reg <= mem[ea_idx];
    end else if (phase_reg == sfw_pkg::SFW_Q3) begin
      res_reg <= alu_diff;
      flg_reg <= {alu_n, alu_sgn_excess, alu_z, alu_half_carry, alu_c};
    end
  end

  // working register: q4 destination or bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_reg <= 8'h00;
    end else if (phase_reg == sfw_pkg::SFW_Q4 && !dest_f) begin
      w_reg <= res_reg;
    end else if (do_wr && aw_addr_reg == `SFW_WREG_OFS) begin
      w_reg <= mrg[7:0];
    end
  end

  // status: five flags in q4, upper bits kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 8'h00;
    end else if (phase_reg == sfw_pkg::SFW_Q4) begin
      stat_reg[`SFW_ST_N:`SFW_ST_C] <= flg_reg;
    end else if (do_wr && aw_addr_reg == `SFW_STAT_OFS) begin
      stat_reg <= mrg[7:0];
    end
  end

  // file registers: q4 destination or bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `SFW_MEM_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (phase_reg == sfw_pkg::SFW_Q4 && dest_f) begin
      mem[ea_idx] <= res_reg;
    end else if (do_wr && is_mem(aw_addr_reg)) begin
      mem[wr_idx] <= mrg[7:0];
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  alu_diff_a: assert property (phase_reg == sfw_pkg::SFW_Q4 |->
    res_reg == 8'(opnd_reg - w_reg)) else $error("difference wrong");
  dest_work_a: assert property (phase_reg == sfw_pkg::SFW_Q4 && !dest_f |=>
    w_reg == $past(res_reg)) else $error("working not written");
  dest_file_a: assert property (phase_reg == sfw_pkg::SFW_Q4 && dest_f |=>
    $stable(w_reg) && mem[$past(ea_idx)] == $past(res_reg)) else $error("file not written");
  access_bank_a: assert property (phase_reg == sfw_pkg::SFW_Q2 &&
    !insn_reg[`SFW_A_BIT] && !(ext_en_reg && fa <= `SFW_ILO_MAX) |->
    ea_reg[11:8] == (fa < `SFW_ACC_SPLIT ? `SFW_ACC_LO : `SFW_ACC_HI))
    else $error("access bank address wrong");
  banked_addr_a: assert property (phase_reg == sfw_pkg::SFW_Q2 &&
    insn_reg[`SFW_A_BIT] |-> ea_reg == {bank_reg, fa}) else $error("banked address wrong");
  indexed_addr_a: assert property (phase_reg == sfw_pkg::SFW_Q2 &&
    !insn_reg[`SFW_A_BIT] && ext_en_reg && fa <= `SFW_ILO_MAX |->
    ea_reg == 12'(idxb_reg + {4'h0, fa})) else $error("indexed address wrong");
  other_bits_a: assert property (phase_reg == sfw_pkg::SFW_Q4 |=>
    stat_reg[7:5] == $past(stat_reg[7:5])) else $error("upper status changed");
  bad_opcode_a: assert property (phase_reg == sfw_pkg::SFW_Q1 && !op_ok |=>
    phase_reg == sfw_pkg::SFW_IDLE && ill_reg) else $error("bad opcode ran");
  one_cycle_a: assert property (phase_reg == sfw_pkg::SFW_Q1 && op_ok |=>
    phase_reg == sfw_pkg::SFW_Q2 ##1 phase_reg == sfw_pkg::SFW_Q3 ##1
    phase_reg == sfw_pkg::SFW_Q4 ##1 phase_reg == sfw_pkg::SFW_IDLE)
    else $error("phase order wrong");
  zero_flags_a: assert property (phase_reg == sfw_pkg::SFW_Q4 && res_reg == 8'h00 |=>
    stat_reg[`SFW_ST_C] && stat_reg[`SFW_ST_Z] && !stat_reg[`SFW_ST_N])
    else $error("zero flags wrong");
  carry_flag_a: assert property (phase_reg == sfw_pkg::SFW_Q4 |=>
    stat_reg[`SFW_ST_C] == ($past(opnd_reg) >= $past(w_reg)) &&
    stat_reg[`SFW_ST_HC] == ($past(opnd_reg[3:0]) >= $past(w_reg[3:0])))
    else $error("carry flags wrong");
  equal_zero_a: assert property (phase_reg == sfw_pkg::SFW_Q4 && !dest_f &&
    opnd_reg == w_reg |=> w_reg == 8'h00 && mem[$past(ea_idx)] == $past(opnd_reg))
    else $error("equal operands wrong");
endmodule // sfw_core

// [verification/sfw_core_tb_top.sv]
// self-checking bench for the subtract core, driven over AXI4-Lite
// assumes sfw_cfg.svh on the include path and sfw_pkg, sfw_sub_alu, sfw_core compiled first
`timescale 1ns/1ps
`include "sfw_cfg.svh"
module sfw_core_tb_top;
  logic aclk = 1'b0; // core clock
  logic aresetn = 1'b0; // sync reset, active low
  logic [11:0] awaddr = 12'h000; // write address
  logic awvalid = 1'b0; // write address valid
  logic awready; // write address ready
  logic [31:0] wdata = 32'h0000_0000; // write data
  logic [3:0] wstrb = 4'h0; // byte strobes
  logic wvalid = 1'b0; // write data valid
  logic wready; // write data ready
  logic [1:0] bresp; // write response
  logic bvalid; // write response valid
  logic bready = 1'b0; // write response ready
  logic [11:0] araddr = 12'h000; // read address
  logic arvalid = 1'b0; // read address valid
  logic arready; // read address ready
  logic [31:0] rdata; // read data
  logic [1:0] rresp; // read response
  logic rvalid; // read data valid
  logic rready = 1'b0; // read data ready
  int n_errors = 0; // mismatches
  int n_tests = 0; // comparisons
  int n_cycles = 0; // timeout counter

  // 100 MHz clock
  always #5 aclk = ~aclk;

  sfw_core dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge aclk) begin
    n_cycles = n_cycles + 1;
    if (n_cycles == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus write, response compared
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // one bus read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // read and compare, okay answer expected
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, 32'h0);
    chk(d, e);
  endtask

  // run one legal instruction and judge address, result, destination and flags
  task automatic do_op(input logic [15:0] insn, input logic [11:0] ea, input logic [7:0] f,
                       input logic [7:0] w);
    logic [7:0] dif;
    logic [7:0] flg;
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] ma;
    dif = f - w;
    flg = {3'h7, dif[7], (f[7] != w[7]) && (dif[7] != f[7]), dif == 8'h00,
           f[3:0] >= w[3:0], f >= w};
    ma = 12'h100 + {4'h0, ea[5:0], 2'h0};
    wr(ma, {24'h0, f}, 4'hF, `SFW_RESP_OK);
    wr(`SFW_WREG_OFS, {24'h0, w}, 4'hF, `SFW_RESP_OK);
    wr(`SFW_STAT_OFS, {24'h0, 3'h7, ~flg[4:0]}, 4'hF, `SFW_RESP_OK);
    wr(`SFW_INSN_OFS, {16'h0, insn}, 4'hF, `SFW_RESP_OK);
    rd(`SFW_EXEC_OFS, d, r);
    chk({31'h0, d[0]}, 32'h1);
    repeat (4) @(posedge aclk);
    rd_chk(`SFW_EXEC_OFS, {4'h0, ea, 16'h0});
    rd_chk(ma, {24'h0, insn[9] ? dif : f});
    rd_chk(`SFW_WREG_OFS, {24'h0, insn[9] ? w : dif});
    rd_chk(`SFW_STAT_OFS, {24'h0, flg});
  endtask

  // reset values, unmapped places, read-only word, byte strobes
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(`SFW_CTRL_OFS, 32'h0);
    rd_chk(`SFW_WREG_OFS, 32'h0);
    rd_chk(`SFW_BANK_OFS, 32'h0);
    rd_chk(`SFW_STAT_OFS, 32'h0);
    rd_chk(`SFW_EXEC_OFS, 32'h0);
    rd(12'h020, d, r);
    chk({30'h0, r}, {30'h0, `SFW_RESP_ERR});
    chk(d, 32'h0);
    wr(12'h020, 32'h1, 4'hF, `SFW_RESP_ERR);
    wr(`SFW_EXEC_OFS, 32'hFFFF_FFFF, 4'hF, `SFW_RESP_OK);
    rd_chk(`SFW_EXEC_OFS, 32'h0);
    wr(`SFW_IDXB_OFS, 32'h0000_0FFF, 4'hF, `SFW_RESP_OK);
    wr(`SFW_IDXB_OFS, 32'h0000_0012, 4'h1, `SFW_RESP_OK);
    rd_chk(`SFW_IDXB_OFS, 32'h0000_0F12);
    $display("test reset done");
  endtask

  // arithmetic corners written back to the file register, then two written to the working register
  task automatic t_arith();
    logic [7:0] ft [0:5] = '{8'h01, 8'h02, 8'h80, 8'h10, 8'h7F, 8'h00};
    logic [7:0] wt [0:5] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'hFF, 8'h00};
    for (int i = 0; i < 6; i++) begin
      do_op(16'h5E10, 12'h010, ft[i], wt[i]);
    end
    do_op(16'h5C10, 12'h010, 8'h3C, 8'h3C);
    do_op(16'h5C10, 12'h010, 8'h05, 8'h09);
    $display("test arithmetic done");
  endtask

  // bank pointer, access bank halves, indexed offset and its limit
  task automatic t_addr();
    wr(`SFW_BANK_OFS, 32'h3, 4'hF, `SFW_RESP_OK);
    do_op(16'h5F25, 12'h325, 8'h40, 8'h11);
    do_op(16'h5E70, 12'hF70, 8'h22, 8'h01);
    wr(`SFW_CTRL_OFS, 32'h1, 4'hF, `SFW_RESP_OK);
    wr(`SFW_IDXB_OFS, 32'h123, 4'hF, `SFW_RESP_OK);
    do_op(16'h5E05, 12'h128, 8'h09, 8'h03);
    do_op(16'h5E5F, 12'h182, 8'h90, 8'h10);
    do_op(16'h5E60, 12'hF60, 8'h33, 8'h44);
    do_op(16'h5F05, 12'h305, 8'h08, 8'h08);
    wr(`SFW_IDXB_OFS, 32'hFF0, 4'hF, `SFW_RESP_OK);
    do_op(16'h5E20, 12'h010, 8'hA0, 8'h0A);
    wr(`SFW_CTRL_OFS, 32'h0, 4'hF, `SFW_RESP_OK);
    do_op(16'h5E05, 12'h005, 8'h06, 8'h02);
    $display("test addressing done");
  endtask

  // foreign opcodes change nothing but the illegal mark and the resolved address
  task automatic t_illegal();
    logic [15:0] bad [0:1] = '{16'h5A10, 16'hBE10};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 2; i++) begin
      wr(12'h140, 32'h55, 4'hF, `SFW_RESP_OK);
      wr(`SFW_WREG_OFS, 32'h11, 4'hF, `SFW_RESP_OK);
      wr(`SFW_STAT_OFS, 32'hA5, 4'hF, `SFW_RESP_OK);
      wr(`SFW_INSN_OFS, {16'h0, bad[i]}, 4'hF, `SFW_RESP_OK);
      repeat (6) @(posedge aclk);
      rd(`SFW_EXEC_OFS, d, r);
      chk(d & 32'h3, 32'h2);
      rd_chk(12'h140, 32'h55);
      rd_chk(`SFW_WREG_OFS, 32'h11);
      rd_chk(`SFW_STAT_OFS, 32'hA5);
      rd_chk(`SFW_INSN_OFS, {16'h0, bad[i]});
    end
    do_op(16'h5E10, 12'h010, 8'h77, 8'h07);
    $display("test illegal done");
  endtask

  // a write offered right after a start waits until the destination is written
  task automatic t_stall();
    wr(12'h140, 32'h20, 4'hF, `SFW_RESP_OK);
    wr(`SFW_WREG_OFS, 32'h05, 4'hF, `SFW_RESP_OK);
    wr(`SFW_INSN_OFS, 32'h5C10, 4'hF, `SFW_RESP_OK);
    wr(`SFW_STAT_OFS, 32'h5A, 4'hF, `SFW_RESP_OK);
    rd_chk(`SFW_STAT_OFS, 32'h5A);
    rd_chk(`SFW_WREG_OFS, 32'h1B);
    rd_chk(12'h140, 32'h20);
    rd_chk(`SFW_EXEC_OFS, 32'h0010_0000);
    $display("test stall done");
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_arith();
    t_addr();
    t_illegal();
    t_stall();
    end_sim();
  end
endmodule // sfw_core_tb_top
